// File: logic/purs_pkg.sv
// Constants, field layouts and types for the power-up reset sequencer
package purs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int REF_CLK_NS = 1_000_000_000 / REF_CLK_HZ;
  localparam int POWER_UP_DELAY_TIMER_TIME_MS = 72;
  localparam int RC_TICK_NS = 1000;
  localparam int RC_DIV_CYCLES = RC_TICK_NS / REF_CLK_NS;
  localparam int POWER_UP_DELAY_TIMER_TICKS = POWER_UP_DELAY_TIMER_TIME_MS * 1_000_000 / RC_TICK_NS;
  localparam int OST_CYCLES = 1024;
  localparam int POR_PULSE_CYCLES = 16;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PCL = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_PC_UPPER_LATCH = 8'h0A;
  localparam logic [7:0] IDX_INTCTL = 8'h0B;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_DIRA = 8'h85;
  localparam logic [7:0] IDX_DIRB = 8'h86;
  localparam logic [7:0] IDX_PFLAGS = 8'h8E;
  localparam logic [7:0] IDX_SEQ_STAT = 8'h90;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [4:0] DIRA_RST = 5'h1F;
  localparam logic [7:0] DIRB_RST = 8'hFF;
  localparam logic [7:0] PCL_RST = 8'h00;
  localparam logic [4:0] PC_UPPER_LATCH_RST = 5'h00;
  localparam int ST_TO_BIT = 4;
  localparam int ST_PD_BIT = 3;
  localparam int PF_POR_BIT = 1;
  localparam int GIE_BIT = 7;
  localparam logic [12:0] PC_RESET_VEC = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC = 13'h0004;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PURS_OSC_LP = 2'b00,
    PURS_OSC_XT = 2'b01,
    PURS_OSC_HS = 2'b10,
    PURS_OSC_RC = 2'b11
  } purs_osc_t;

  typedef enum logic [2:0] {
    SQ_POR = 3'b000,
    SQ_POWER_UP_DELAY_TIMER = 3'b001,
    SQ_OST = 3'b010,
    SQ_READY = 3'b011,
    SQ_SLEEP = 3'b100
  } purs_state_t;

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000,
    CAUSE_POR = 3'b001,
    CAUSE_MASTER_CLEAR_PIN_N_RUN = 3'b010,
    CAUSE_MASTER_CLEAR_PIN_N_SLEEP = 3'b011,
    CAUSE_WDT_RST = 3'b100,
    CAUSE_WDT_WAKE = 3'b101,
    CAUSE_IRQ_WAKE = 3'b110
  } purs_cause_t;

endpackage

// File: logic/purs_sequencer.sv
// Power-up reset sequencer with reset-cause registers on Avalon-MM
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module purs_sequencer
  import purs_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_TICK_COUNT = POWER_UP_DELAY_TIMER_TICKS,
  parameter int OST_COUNT = OST_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic vdd_above_thresh,
  input wire logic master_clear_pin_n,
  input wire logic osc_input_pin,
  input wire logic osc_select_cfg_hi,
  input wire logic osc_select_cfg_lo,
  input wire logic power_delay_cfg_n,
  input wire logic sleep_enter,
  input wire logic wdt_timeout,
  input wire logic irq_wake,
  input wire logic [7:0] irq_wake_flags,
  input wire logic [12:0] pc_current,
  input wire logic instr_done,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic core_reset_n,
  output logic pc_load,
  output logic [12:0] pc_load_addr
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  purs_state_t state_r;
  purs_cause_t cause_r;
  purs_osc_t osc_mode;
  logic vdd_prev_r;
  logic osc_prev_r;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0] rc_div_r;
  logic rc_tick;
  logic osc_rise;
  logic crystal;
  logic por_evt;
  logic ev_master_clear_pin_n_run, ev_master_clear_pin_n_sleep, ev_wdt_rst, ev_wdt_wake, ev_irq_wake;
  logic reset_any, wake_any;
  logic core_reset_n_r;
  logic wake_pend_r, wake_irq_r, vec_pend_r, resume_go;
  logic pc_load_r;
  logic [12:0] pc_load_addr_r;
  logic [12:0] pc_next;
  logic [7:0] status_r, intctl_r, option_r, dirb_r, pcl_r;
  logic [4:0] dira_r, pc_upper_latch_r;
  logic pf_por_r;
  logic ack_r;
  logic [31:0] readdata_r;
  logic [7:0] reg_idx;
  logic wr_en;

  // ----------------------------------------------------------------
  // Register index helpers
  // ----------------------------------------------------------------
  // Write decode shared by every register process
  function automatic logic wr_hit(input logic [7:0] idx,
                                  input logic [7:0] want);
    wr_hit = (idx == want);
  endfunction

  // Read mux; unmapped and out-of-scope indices read zero
  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    if (idx == IDX_PCL) begin
      reg_read = pcl_r;
    end else if (idx == IDX_STATUS) begin
      reg_read = status_r;
    end else if (idx == IDX_PC_UPPER_LATCH) begin
      reg_read = {3'h0, pc_upper_latch_r};
    end else if (idx == IDX_INTCTL) begin
      reg_read = intctl_r;
    end else if (idx == IDX_OPTION) begin
      reg_read = option_r;
    end else if (idx == IDX_DIRA) begin
      reg_read = {3'h0, dira_r};
    end else if (idx == IDX_DIRB) begin
      reg_read = dirb_r;
    end else if (idx == IDX_PFLAGS) begin
      reg_read = {6'h00, pf_por_r, 1'b0};
    end else if (idx == IDX_SEQ_STAT) begin
      reg_read = {cause_r, state_r, wake_pend_r, core_reset_n_r};
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  // ----------------------------------------------------------------
  // Edge detection and mode decode
  // ----------------------------------------------------------------
  // Input samples for supply and oscillator edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vdd_prev_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      vdd_prev_r <= vdd_above_thresh;
      osc_prev_r <= osc_input_pin;
    end
  end

  // Only a rise fires; a falling supply is ignored
  assign por_evt = vdd_above_thresh & ~vdd_prev_r;
  assign osc_rise = osc_input_pin & ~osc_prev_r;
  assign osc_mode = purs_osc_t'({osc_select_cfg_hi, osc_select_cfg_lo});
  assign crystal = (osc_mode != PURS_OSC_RC);

  // ----------------------------------------------------------------
  // Reset-cause events, power-on first
  // ----------------------------------------------------------------
  assign ev_master_clear_pin_n_run = ~por_evt & ~master_clear_pin_n &
                       (state_r != SQ_SLEEP);
  assign ev_master_clear_pin_n_sleep = ~por_evt & ~master_clear_pin_n &
                         (state_r == SQ_SLEEP);
  assign ev_wdt_rst = ~por_evt & master_clear_pin_n & wdt_timeout &
                      (state_r == SQ_READY);
  assign ev_wdt_wake = ~por_evt & master_clear_pin_n & wdt_timeout &
                       (state_r == SQ_SLEEP);
  assign ev_irq_wake = ~por_evt & master_clear_pin_n & ~wdt_timeout &
                       irq_wake & (state_r == SQ_SLEEP);
  assign reset_any = por_evt | ev_master_clear_pin_n_run | ev_master_clear_pin_n_sleep | ev_wdt_rst;
  assign wake_any = ev_wdt_wake | ev_irq_wake;

  // ----------------------------------------------------------------
  // Internal RC tick divider
  // ----------------------------------------------------------------
  // Stands in for the slow RC clock as a one-cycle enable
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_div_r <= 8'h00;
    end else if (state_r != SQ_POWER_UP_DELAY_TIMER || rc_tick) begin
      rc_div_r <= 8'h00;
    end else begin
      rc_div_r <= rc_div_r + 8'h01;
    end
  end

  assign rc_tick = (rc_div_r == 8'(RC_DIV_CYCLES - 1));

  // ----------------------------------------------------------------
  // Time-out sequencer
  // ----------------------------------------------------------------
  // Runs from the power-on pulse whatever the master clear pin does
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SQ_POR;
      cnt_r <= '0;
    end else if (por_evt) begin
      state_r <= SQ_POR;
      cnt_r <= '0;
    end else begin
      case (state_r)
        SQ_POR: begin
          if (cnt_r == CNT_W'(POR_PULSE_CYCLES - 1)) begin
            cnt_r <= '0;
            if (!power_delay_cfg_n) begin
              state_r <= SQ_POWER_UP_DELAY_TIMER;
            end else if (crystal) begin
              state_r <= SQ_OST;
            end else begin
              state_r <= SQ_READY;
            end
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        SQ_POWER_UP_DELAY_TIMER: begin
          if (rc_tick) begin
            if (cnt_r == CNT_W'(POWER_UP_DELAY_TIMER_TICK_COUNT - 1)) begin
              cnt_r <= '0;
              state_r <= crystal ? SQ_OST : SQ_READY;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        SQ_OST: begin
          if (osc_rise) begin
            if (cnt_r == CNT_W'(OST_COUNT - 1)) begin
              cnt_r <= '0;
              state_r <= SQ_READY;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        SQ_READY: begin
          if (master_clear_pin_n && !wdt_timeout && sleep_enter) begin
            state_r <= SQ_SLEEP;
          end
        end
        SQ_SLEEP: begin
          cnt_r <= '0;
          if (ev_master_clear_pin_n_sleep) begin
            state_r <= SQ_READY;
          end else if (wake_any) begin
            state_r <= crystal ? SQ_OST : SQ_READY;
          end
        end
        default: begin
          state_r <= SQ_POR;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core reset output
  // ----------------------------------------------------------------
  // Registered so the core never sees a glitch from the event decode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reset_n_r <= 1'b0;
    end else begin
      core_reset_n_r <= master_clear_pin_n & ~por_evt & ~ev_wdt_rst &
                        (state_r == SQ_READY || state_r == SQ_SLEEP);
    end
  end

  assign core_reset_n = core_reset_n_r;

  // ----------------------------------------------------------------
  // Last reset cause, visible in the sequencer status register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_r <= CAUSE_NONE;
    end else if (por_evt) begin
      cause_r <= CAUSE_POR;
    end else if (ev_master_clear_pin_n_sleep) begin
      cause_r <= CAUSE_MASTER_CLEAR_PIN_N_SLEEP;
    end else if (ev_master_clear_pin_n_run) begin
      cause_r <= CAUSE_MASTER_CLEAR_PIN_N_RUN;
    end else if (ev_wdt_rst) begin
      cause_r <= CAUSE_WDT_RST;
    end else if (ev_wdt_wake) begin
      cause_r <= CAUSE_WDT_WAKE;
    end else if (ev_irq_wake) begin
      cause_r <= CAUSE_IRQ_WAKE;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up bookkeeping and program counter loads
  // ----------------------------------------------------------------
  // In crystal modes resume waits for the settle count, so the core
  // restarts on a stable clock; resistor-cap mode resumes at once
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_pend_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end else if (reset_any) begin
      wake_pend_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end else if (wake_any) begin
      wake_pend_r <= 1'b1;
      wake_irq_r <= ev_irq_wake;
    end else if (resume_go) begin
      wake_pend_r <= 1'b0;
    end
  end

  assign resume_go = wake_pend_r & (state_r == SQ_READY);
  assign pc_next = pc_current + 13'h0001;

  // Vector is taken only after the instruction at PC+1 retires
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_pend_r <= 1'b0;
    end else if (reset_any) begin
      vec_pend_r <= 1'b0;
    end else if (resume_go) begin
      vec_pend_r <= wake_irq_r & intctl_r[GIE_BIT];
    end else if (instr_done) begin
      vec_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_load_r <= 1'b0;
      pc_load_addr_r <= PC_RESET_VEC;
    end else if (reset_any) begin
      pc_load_r <= 1'b1;
      pc_load_addr_r <= PC_RESET_VEC;
    end else if (resume_go) begin
      pc_load_r <= 1'b1;
      pc_load_addr_r <= pc_next;
    end else if (vec_pend_r && instr_done) begin
      pc_load_r <= 1'b1;
      pc_load_addr_r <= PC_IRQ_VEC;
    end else begin
      pc_load_r <= 1'b0;
    end
  end

  assign pc_load = pc_load_r;
  assign pc_load_addr = pc_load_addr_r;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ----------------------------------------------------------------
  assign reg_idx = avs_address[9:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_en = avs_write & ack_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // Read data captured early so it stands at the completing edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      readdata_r <= {24'h00_0000, reg_read(reg_idx)};
    end
  end

  assign avs_readdata = readdata_r;

  // ----------------------------------------------------------------
  // Core status: cause loads win over a software write
  // ----------------------------------------------------------------
  // Timeout and power-down bits are read-only to software
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= 8'h18;
    end else if (por_evt) begin
      status_r[7:3] <= 5'b00011;
    end else if (ev_master_clear_pin_n_sleep) begin
      status_r[7:3] <= 5'b00010;
    end else if (ev_master_clear_pin_n_run) begin
      status_r[7:5] <= 3'b000;
    end else if (ev_wdt_rst) begin
      status_r[7:4] <= 4'b0000;
    end else if (ev_wdt_wake) begin
      status_r[ST_TO_BIT] <= 1'b0;
      status_r[ST_PD_BIT] <= 1'b0;
    end else if (ev_irq_wake) begin
      status_r[ST_TO_BIT] <= 1'b1;
      status_r[ST_PD_BIT] <= 1'b0;
    end else if (wr_en && wr_hit(reg_idx, IDX_STATUS)) begin
      status_r[7:5] <= avs_writedata[7:5];
      status_r[2:0] <= avs_writedata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Power flags: power-on clears, software writes either value
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pf_por_r <= 1'b0;
    end else if (por_evt) begin
      pf_por_r <= 1'b0;
    end else if (wr_en && wr_hit(reg_idx, IDX_PFLAGS)) begin
      pf_por_r <= avs_writedata[PF_POR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt control: bits 7:1 cleared on reset, wake flag merged on interrupt wake
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      intctl_r <= 8'h00;
    end else if (reset_any) begin
      intctl_r[7:1] <= 7'h00;
    end else if (ev_irq_wake) begin
      intctl_r <= intctl_r | irq_wake_flags;
    end else if (wr_en && wr_hit(reg_idx, IDX_INTCTL)) begin
      intctl_r <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Option and direction registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      option_r <= OPTION_RST;
      dira_r <= DIRA_RST;
      dirb_r <= DIRB_RST;
    end else if (reset_any) begin
      option_r <= OPTION_RST;
      dira_r <= DIRA_RST;
      dirb_r <= DIRB_RST;
    end else if (wr_en) begin
      if (wr_hit(reg_idx, IDX_OPTION)) begin
        option_r <= avs_writedata[7:0];
      end else if (wr_hit(reg_idx, IDX_DIRA)) begin
        dira_r <= avs_writedata[4:0];
      end else if (wr_hit(reg_idx, IDX_DIRB)) begin
        dirb_r <= avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter low byte and upper latch
  // ----------------------------------------------------------------
  // Wake-up leaves the upper latch alone; low byte tracks PC+1
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcl_r <= PCL_RST;
      pc_upper_latch_r <= PC_UPPER_LATCH_RST;
    end else if (reset_any) begin
      pcl_r <= PCL_RST;
      pc_upper_latch_r <= PC_UPPER_LATCH_RST;
    end else if (resume_go) begin
      pcl_r <= pc_next[7:0];
    end else if (wr_en) begin
      if (wr_hit(reg_idx, IDX_PCL)) begin
        pcl_r <= avs_writedata[7:0];
      end else if (wr_hit(reg_idx, IDX_PC_UPPER_LATCH)) begin
        pc_upper_latch_r <= avs_writedata[4:0];
      end
    end
  end

endmodule

`default_nettype wire

// File: testbench/purs_osc_model.sv
// Far-side model: external oscillator driving the clock input pin
`timescale 1ns/100ps
`default_nettype none
module purs_osc_model (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic slow,
  output var logic osc_input_pin
);
  int cnt = 0;
  initial osc_input_pin = 1'b0;
  // Toggles only while run; a stopped crystal holds the pin low and gives no rising edges
  always @(posedge ref_clk) begin
    cnt <= (cnt >= (slow ? 4 : 1)) ? 0 : cnt + 1;
    if (!run)
      osc_input_pin <= 1'b0;
    else if (cnt == 0)
      osc_input_pin <= !osc_input_pin;
  end
endmodule
`default_nettype wire

// File: testbench/purs_sequencer_checker.sv
// Port-level assertions for the power-up reset sequencer
`timescale 1ns/100ps
`default_nettype none
module purs_sequencer_checker
  import purs_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_TICK_COUNT = 4,
  parameter int OST_COUNT = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic vdd_above_thresh,
  input wire logic master_clear_pin_n,
  input wire logic osc_select_cfg_hi,
  input wire logic osc_select_cfg_lo,
  input wire logic power_delay_cfg_n,
  input wire logic wdt_timeout,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic core_reset_n,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_addr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Delay figures assume the short counts the bench sets (4 and 4)
  pin_hold_a: assert property (!master_clear_pin_n |=> !core_reset_n)
    else $error("core reset released while pin low");
  por_pulse_a: assert property ($rose(vdd_above_thresh) |=> !core_reset_n[*8])
    else $error("supply rise gave no reset pulse");
  vdd_fall_a: assert property (($fell(vdd_above_thresh) && core_reset_n
    && master_clear_pin_n && !wdt_timeout) |=> core_reset_n)
    else $error("supply fall caused a reset");
  pc_zero_a: assert property ($fell(master_clear_pin_n)
    |=> pc_load && pc_load_addr == PC_RESET_VEC)
    else $error("pin reset did not load address zero");
  rc_fast_a: assert property (($rose(vdd_above_thresh) && osc_select_cfg_hi
    && osc_select_cfg_lo && power_delay_cfg_n && master_clear_pin_n)
    |-> ##[1:24] core_reset_n)
    else $error("resistor-cap start took too long");
  power_up_delay_timer_hold_a: assert property (($rose(vdd_above_thresh)
    && !power_delay_cfg_n) |-> ##300 !core_reset_n)
    else $error("power-up delay ended early");
  ost_hold_a: assert property (($rose(vdd_above_thresh)
    && !(osc_select_cfg_hi && osc_select_cfg_lo)) |-> ##18 !core_reset_n)
    else $error("settle count skipped in crystal mode");
  bus_wait_a: assert property (($rose(avs_read) || $rose(avs_write))
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait state wrong");
endmodule
`default_nettype wire

// File: testbench/purs_sequencer_tb.sv
// Self-checking bench for the power-up reset sequencer
`timescale 1ns/100ps
`default_nettype none
module purs_sequencer_tb;
  import purs_pkg::*;
  logic ref_clk = 0, rst_b = 0, vdd = 0, pin_n = 1, hi = 1, lo = 1;
  logic cfg_n = 1, slp = 0, wdt = 0, irq = 0, idone = 0, rd = 0, wr = 0;
  logic osc, run = 0, slow = 0, waitreq, crst_n, pcl_ld;
  logic [7:0] irqf = 8'h00, v;
  logic [12:0] pc = 13'h0000, pc_addr, p;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [7:0] rd_q[$];
  logic [12:0] pc_q[$] = '{13'h0000};
  int n_errors = 0, total_checks = 0, cyc = 0;
  purs_sequencer #(.POWER_UP_DELAY_TIMER_TICK_COUNT(4), .OST_COUNT(4)) u_purs_sequencer (
    .ref_clk, .rst_b, .vdd_above_thresh(vdd), .master_clear_pin_n(pin_n),
    .osc_input_pin(osc), .osc_select_cfg_hi(hi), .osc_select_cfg_lo(lo),
    .power_delay_cfg_n(cfg_n), .sleep_enter(slp), .wdt_timeout(wdt),
    .irq_wake(irq), .irq_wake_flags(irqf), .pc_current(pc),
    .instr_done(idone), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .core_reset_n(crst_n), .pc_load(pcl_ld), .pc_load_addr(pc_addr));
  purs_osc_model u_purs_osc_model (.ref_clk, .run, .slow,
    .osc_input_pin(osc));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    @(posedge ref_clk);
    while (waitreq !== 1'b0) @(posedge ref_clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] idx, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask
  // Lets the drop land first, then waits a bounded time for release
  task automatic wait_run(input int n);
    tick(2);
    for (int i = 0; i < n && crst_n !== 1'b1; i++) @(posedge ref_clk);
    chk({31'h0, crst_n}, 32'h1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and result monitor
  // ----------------------------------------------------------------
  initial forever #5 ref_clk = !ref_clk;
  // Repeated loads while the pin is low keep matching the newest note
  always @(posedge ref_clk) begin
    cyc++;
    if (rd === 1'b1 && waitreq === 1'b0 && rd_q.size() > 0)
      chk(rdata, {24'h000000, rd_q.pop_front()});
    if (pcl_ld === 1'b1) begin
      if (pc_q.size() > 1)
        void'(pc_q.pop_front());
      chk({19'h0, pc_addr}, {19'h0, pc_q[0]});
    end
    if (cyc == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(59));
    tick(10);
    rst_b <= 1'b1;
    rdx(IDX_OPTION, OPTION_RST);
    rdx(IDX_DIRA, {3'h0, DIRA_RST});
    rdx(IDX_DIRB, DIRB_RST);
    rdx(IDX_PC_UPPER_LATCH, {3'h0, PC_UPPER_LATCH_RST});
    rdx(IDX_PCL, PCL_RST);
    rdx(IDX_INTCTL, 8'h00);
    rdx(8'h20, 8'h00);
    // Resistor-cap power-on with the delay skipped
    vdd <= 1'b1;
    wait_run(40);
    rdx(IDX_STATUS, 8'h18);
    rdx(IDX_PFLAGS, 8'h00);
    bus(1'b1, IDX_PFLAGS, 8'h02);
    rdx(IDX_PFLAGS, 8'h02);
    bus(1'b1, IDX_STATUS, 8'hE7);
    rdx(IDX_STATUS, 8'hFF);
    // Pin reset while running, low-power crystal selected
    hi <= 1'b0;
    lo <= 1'b0;
    run <= 1'b1;
    v = 8'($urandom);
    bus(1'b1, IDX_OPTION, v);
    rdx(IDX_OPTION, v);
    pc_q.push_back(PC_RESET_VEC);
    pin_n <= 1'b0;
    tick(5);
    pin_n <= 1'b1;
    wait_run(20);
    rdx(IDX_STATUS, 8'h1F);
    rdx(IDX_OPTION, OPTION_RST);
    rdx(IDX_PFLAGS, 8'h02);
    // Watchdog reset, then pin reset during sleep
    pc_q.push_back(PC_RESET_VEC);
    wdt <= 1'b1;
    tick(1);
    wdt <= 1'b0;
    wait_run(20);
    rdx(IDX_STATUS, 8'h0F);
    hi <= 1'b0;
    lo <= 1'b1;
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(2);
    pin_n <= 1'b0;
    tick(5);
    pin_n <= 1'b1;
    wait_run(20);
    rdx(IDX_STATUS, 8'h17);
    // Watchdog wake in standard crystal mode, slow oscillator
    slow <= 1'b1;
    bus(1'b1, IDX_OPTION, 8'h5A);
    p = 13'($urandom);
    pc <= p;
    pc_q.push_back(p + 13'h1);
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(2);
    wdt <= 1'b1;
    tick(1);
    wdt <= 1'b0;
    tick(80);
    chk(32'(pc_q.size()), 32'h1);
    rdx(IDX_STATUS, 8'h07);
    rdx(IDX_OPTION, 8'h5A);
    // Interrupt wake in resistor-cap mode with global enable set
    hi <= 1'b1;
    lo <= 1'b1;
    run <= 1'b0;
    bus(1'b1, IDX_INTCTL, 8'h80);
    p = 13'($urandom);
    pc <= p;
    pc_q.push_back(p + 13'h1);
    pc_q.push_back(PC_IRQ_VEC);
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(2);
    irqf <= 8'h02;
    irq <= 1'b1;
    tick(1);
    irq <= 1'b0;
    rdx(IDX_INTCTL, 8'h82);
    rdx(IDX_STATUS, 8'h17);
    idone <= 1'b1;
    tick(1);
    idone <= 1'b0;
    tick(3);
    chk(32'(pc_q.size()), 32'h1);
    // Supply cycles in high-speed crystal mode, delay off then on
    hi <= 1'b1;
    lo <= 1'b0;
    run <= 1'b1;
    slow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, IDX_PFLAGS, 8'h02);
      pc_q.push_back(PC_RESET_VEC);
      cfg_n <= (k == 0);
      vdd <= 1'b0;
      tick(3);
      pin_n <= (k == 0);
      vdd <= 1'b1;
      if (k == 1) begin
        tick(600);
        pin_n <= 1'b1;
      end
      wait_run(k == 1 ? 4 : 60);
      rdx(IDX_PFLAGS, 8'h00);
      rdx(IDX_STATUS, 8'h1F);
    end
    tally_and_finish();
  end
endmodule
bind purs_sequencer purs_sequencer_checker #(
  .POWER_UP_DELAY_TIMER_TICK_COUNT(POWER_UP_DELAY_TIMER_TICK_COUNT), .OST_COUNT(OST_COUNT))
  u_purs_sequencer_checker (.ref_clk, .rst_b, .vdd_above_thresh,
  .master_clear_pin_n, .osc_select_cfg_hi, .osc_select_cfg_lo,
  .power_delay_cfg_n, .wdt_timeout, .avs_read, .avs_write,
  .avs_waitrequest, .core_reset_n, .pc_load, .pc_load_addr);
`default_nettype wire
